// >>> common/dtic_defs.svh
// Purpose: Offsets, field positions, reset values and counts of the timer block.
// Assumes: Register indices are word indices; byte address is four times index.
// Notes: Definitions only.
`ifndef DTIC_DEFS_SVH
`define DTIC_DEFS_SVH
`define DTIC_IDX_CTRL 8'h88
`define DTIC_IDX_MODE 8'h89
`define DTIC_IDX_T0LO 8'h8a
`define DTIC_IDX_T1LO 8'h8b
`define DTIC_IDX_T0HI 8'h8c
`define DTIC_IDX_T1HI 8'h8d
`define DTIC_IDX_CLKSEL 8'h8e
`define DTIC_IDX_VACK 8'h90
`define DTIC_CTRL_TF1 7
`define DTIC_CTRL_TR1 6
`define DTIC_CTRL_TF0 5
`define DTIC_CTRL_TR0 4
`define DTIC_CTRL_IE1 3
`define DTIC_CTRL_IT1 2
`define DTIC_CTRL_IE0 1
`define DTIC_CTRL_IT0 0
`define DTIC_MODE_GATE1 7
`define DTIC_MODE_CT1 6
`define DTIC_MODE_GATE0 3
`define DTIC_MODE_CT0 2
`define DTIC_CLK_T1U 4
`define DTIC_CLK_T0U 3
`define DTIC_VACK_EXTA 0
`define DTIC_VACK_TF0 1
`define DTIC_VACK_EXTB 2
`define DTIC_VACK_TF1 3
`define DTIC_RST_BYTE 8'h00
`define DTIC_PRESCALE 4'hc
`define DTIC_M0_LOW_MAX 5'h1f
`define DTIC_RESP_OKAY 2'b00
`define DTIC_RESP_SLVERR 2'b10
`endif

// >>> common/dtic_pkg.sv
// Purpose: Types shared by the timer block.
// Assumes: Nothing beyond the defs header.
// Notes: Mode encodings follow the two mode bits of each timer.
package dtic_pkg;
  typedef enum logic [1:0] {
    dtic_mode_13bit = 2'h0,
    dtic_mode_16bit = 2'h1,
    dtic_mode_reload = 2'h2,
    dtic_mode_split = 2'h3
  } dtic_mode_type;
endpackage

// >>> design/dtic_count_unit.sv
// Purpose: One timer's low and high count bytes in all four modes.
// Assumes: Increments arrive as single-cycle enables from the top.
// Notes: A software write to a byte wins over a count in the same cycle.
`timescale 1ns/1ps
`default_nettype none
`include "dtic_defs.svh"
module dtic_count_unit
  import dtic_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire dtic_mode_type mode,
  input wire logic inc_lo,
  input wire logic inc_hi,
  input wire logic wr_lo,
  input wire logic wr_hi,
  input wire logic [7:0] wdata,
  output logic [7:0] lo,
  output logic [7:0] hi,
  output logic ovf_lo,
  output logic ovf_hi
);
  logic [7:0] lo_ff;
  logic [7:0] hi_ff;
  logic [7:0] nxt_lo;
  logic [7:0] nxt_hi;

  always_comb begin
    nxt_lo = lo_ff;
    nxt_hi = hi_ff;
    ovf_lo = 1'b0;
    ovf_hi = 1'b0;
    case (mode)
      dtic_mode_13bit: begin
        if (inc_lo) begin
          nxt_lo[4:0] = lo_ff[4:0] + 5'h01;
          if (lo_ff[4:0] == `DTIC_M0_LOW_MAX) begin
            nxt_hi = hi_ff + 8'h01;
            ovf_lo = (hi_ff == 8'hff);
          end
        end
      end
      dtic_mode_16bit: begin
        if (inc_lo) begin
          {nxt_hi, nxt_lo} = {hi_ff, lo_ff} + 16'h0001;
          ovf_lo = &{hi_ff, lo_ff};
        end
      end
      dtic_mode_reload: begin
        if (inc_lo) begin
          if (lo_ff == 8'hff) begin
            nxt_lo = hi_ff;
            ovf_lo = 1'b1;
          end else begin
            nxt_lo = lo_ff + 8'h01;
          end
        end
      end
      dtic_mode_split: begin
        if (inc_lo) begin
          nxt_lo = lo_ff + 8'h01;
          ovf_lo = &lo_ff;
        end
        if (inc_hi) begin
          nxt_hi = hi_ff + 8'h01;
          ovf_hi = &hi_ff;
        end
      end
      default: begin
      end
    endcase
    if (wr_lo) begin
      nxt_lo = wdata;
    end
    if (wr_hi) begin
      nxt_hi = wdata;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lo_ff <= `DTIC_RST_BYTE;
      hi_ff <= `DTIC_RST_BYTE;
    end else begin
      lo_ff <= nxt_lo;
      hi_ff <= nxt_hi;
    end
  end

  assign lo = lo_ff;
  assign hi = hi_ff;
endmodule // dtic_count_unit
`default_nettype wire

// >>> design/dtic_timer_top.sv
// Purpose: Two timer/counters with external interrupt flags, AXI4-Lite slave.
// Assumes: Pins are asynchronous; the core acknowledges vectoring by a write.
// Notes: Flags are level outputs for the core's interrupt logic.
//
// How it works
// - Timer 1 overflow sets its flag; vectoring to its routine clears it.
// - Timer 0 overflow sets its flag; vectoring to its routine clears it.
// - Timer 0 low byte counts only while its own run bit is one; timer 1 also counts while timer 0 is split.
// - Edge mode B: falling pin edge sets pending; vector or software clears.
// - Level mode B: pending follows low pin; software writes ignored.
// - Edge mode A: falling pin edge sets pending; vector or software clears.
// - Level mode A: pending set while pin low, cleared while high.
// - Type bit B selects falling edge when one, low level when zero.
// - Type bit A selects falling edge when one, low level when zero.
// - Mode 0: low five bits count to 31, then carry into high byte.
// - Mode 0 wraps past 0x1FFF to zero and sets the overflow flag.
// - Gate bit set also requires the timer's external interrupt pin to be high.
// - Counter-select bit picks internal clock or external event counting.
// - Mode 1 is a full 16-bit counter wrapping after 0xFFFF.
// - Mode 2 low byte counts and reloads from high byte on overflow.
// - Mode 3 splits timer 0; high half uses timer 1 run and flag.
// - With timer 0 split, timer 1 counts but never sets its flag.
// - Timer 1 in mode 3 stops and holds its count.
// - Mode bits 00, 01, 10, 11 select modes 0 to 3.
// - Gate clear: run bit alone; gate set: pin must also be high.
// - Counter operation increments on each sampled one-to-zero pin edge.
// - Timer clock is clk/12 when clock-select is zero, else clk.
`timescale 1ns/1ps
`default_nettype none
`include "dtic_defs.svh"
module dtic_timer_top
  import dtic_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic ext_irq_pin_a,
  input wire logic ext_irq_pin_b,
  input wire logic tmr0_event_pin,
  input wire logic tmr1_event_pin,
  output logic tmr0_ovf_flag,
  output logic tmr1_ovf_flag,
  output logic ext_irq_a_pending,
  output logic ext_irq_b_pending
);
  logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic aw_hold_ff, w_hold_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff;
  logic [ADDR_W-1:0] awaddr_ff;
  logic [7:0] wd_ff;
  logic wstrb0_ff;
  logic wr_go, wr_sel, wr_hit;
  logic wr_ctrl, wr_mode, wr_clk, wr_vack;
  logic wr_t0lo, wr_t0hi, wr_t1lo, wr_t1hi;
  logic rd_hit;
  logic [7:0] rd_val;
  logic [7:0] mode_ff;
  logic tr0_ff, tr1_ff, it0_ff, it1_ff, t0u_ff, t1u_ff;
  logic tf0_ff, tf1_ff, ie0_ff, ie1_ff;
  logic [3:0] pin_meta_ff, pin_sync_ff, pin_last_ff;
  logic [3:0] fall;
  logic [3:0] div_ff;
  logic tick12;
  dtic_mode_type m0, m1;
  logic t0_split, run0, run1, src0, src1;
  logic inc0_lo, inc0_hi, inc1_lo;
  logic [7:0] t0_lo, t0_hi, t1_lo, t1_hi;
  logic ovf0_lo, ovf0_hi, ovf1_lo;
  logic set_tf1;

  // Write channel: address and data are taken independently, then joined.
  assign wr_go = aw_hold_ff && w_hold_ff && !bvalid_ff;
  assign wr_sel = wr_go && wstrb0_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_ff <= 1'b0;
      awready_ff <= 1'b0;
      awaddr_ff <= '0;
    end else if (wr_go) begin
      aw_hold_ff <= 1'b0;
      awready_ff <= 1'b1;
    end else if (awvalid && awready_ff) begin
      aw_hold_ff <= 1'b1;
      awready_ff <= 1'b0;
      awaddr_ff <= awaddr;
    end else begin
      awready_ff <= !aw_hold_ff;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_ff <= 1'b0;
      wready_ff <= 1'b0;
      wd_ff <= 8'h00;
      wstrb0_ff <= 1'b0;
    end else if (wr_go) begin
      w_hold_ff <= 1'b0;
      wready_ff <= 1'b1;
    end else if (wvalid && wready_ff) begin
      w_hold_ff <= 1'b1;
      wready_ff <= 1'b0;
      wd_ff <= wdata[7:0];
      wstrb0_ff <= wstrb[0];
    end else begin
      wready_ff <= !w_hold_ff;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= `DTIC_RESP_OKAY;
    end else if (wr_go) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= wr_hit ? `DTIC_RESP_OKAY : `DTIC_RESP_SLVERR;
    end else if (bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  always_comb begin
    wr_hit = 1'b1;
    wr_ctrl = 1'b0;
    wr_mode = 1'b0;
    wr_clk = 1'b0;
    wr_vack = 1'b0;
    wr_t0lo = 1'b0;
    wr_t0hi = 1'b0;
    wr_t1lo = 1'b0;
    wr_t1hi = 1'b0;
    case (awaddr_ff[9:2])
      `DTIC_IDX_CTRL: wr_ctrl = wr_sel;
      `DTIC_IDX_MODE: wr_mode = wr_sel;
      `DTIC_IDX_T0LO: wr_t0lo = wr_sel;
      `DTIC_IDX_T1LO: wr_t1lo = wr_sel;
      `DTIC_IDX_T0HI: wr_t0hi = wr_sel;
      `DTIC_IDX_T1HI: wr_t1hi = wr_sel;
      `DTIC_IDX_CLKSEL: wr_clk = wr_sel;
      `DTIC_IDX_VACK: wr_vack = wr_sel;
      default: wr_hit = 1'b0;
    endcase
  end

  // Read channel: one read at a time, data registered on acceptance.
  always_comb begin
    rd_hit = 1'b1;
    case (araddr[9:2])
      `DTIC_IDX_CTRL: rd_val = {tf1_ff, tr1_ff, tf0_ff, tr0_ff,
                                ie1_ff, it1_ff, ie0_ff, it0_ff};
      `DTIC_IDX_MODE: rd_val = mode_ff;
      `DTIC_IDX_T0LO: rd_val = t0_lo;
      `DTIC_IDX_T1LO: rd_val = t1_lo;
      `DTIC_IDX_T0HI: rd_val = t0_hi;
      `DTIC_IDX_T1HI: rd_val = t1_hi;
      `DTIC_IDX_CLKSEL: rd_val = {3'h0, t1u_ff, t0u_ff, 3'h0};
      `DTIC_IDX_VACK: rd_val = 8'h00;
      default: begin
        rd_val = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= `DTIC_RESP_OKAY;
    end else if (arvalid && arready_ff) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rdata_ff <= {24'h00_0000, rd_val};
      rresp_ff <= rd_hit ? `DTIC_RESP_OKAY : `DTIC_RESP_SLVERR;
    end else if (rvalid_ff && rready) begin
      rvalid_ff <= 1'b0;
      arready_ff <= 1'b1;
    end else begin
      arready_ff <= !rvalid_ff;
    end
  end

  // Plain control bits.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tr0_ff <= 1'b0;
      tr1_ff <= 1'b0;
      it0_ff <= 1'b0;
      it1_ff <= 1'b0;
    end else if (wr_ctrl) begin
      tr1_ff <= wd_ff[`DTIC_CTRL_TR1];
      tr0_ff <= wd_ff[`DTIC_CTRL_TR0];
      it1_ff <= wd_ff[`DTIC_CTRL_IT1];
      it0_ff <= wd_ff[`DTIC_CTRL_IT0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_ff <= `DTIC_RST_BYTE;
    end else if (wr_mode) begin
      mode_ff <= wd_ff;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      t0u_ff <= 1'b0;
      t1u_ff <= 1'b0;
    end else if (wr_clk) begin
      t0u_ff <= wd_ff[`DTIC_CLK_T0U];
      t1u_ff <= wd_ff[`DTIC_CLK_T1U];
    end
  end

  // Pins: two stages before any logic, a third stage for edge detection.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta_ff <= 4'hf;
      pin_sync_ff <= 4'hf;
      pin_last_ff <= 4'hf;
    end else begin
      pin_meta_ff <= {tmr1_event_pin, tmr0_event_pin,
                      ext_irq_pin_b, ext_irq_pin_a};
      pin_sync_ff <= pin_meta_ff;
      pin_last_ff <= pin_sync_ff;
    end
  end

  assign fall = pin_last_ff & ~pin_sync_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_ff <= 4'h0;
    end else if (tick12) begin
      div_ff <= 4'h0;
    end else begin
      div_ff <= div_ff + 4'h1;
    end
  end

  assign tick12 = (div_ff == 4'(`DTIC_PRESCALE - 4'h1));

  // Count enables.
  assign m0 = dtic_mode_type'(mode_ff[1:0]);
  assign m1 = dtic_mode_type'(mode_ff[5:4]);
  assign t0_split = (m0 == dtic_mode_split);
  assign src0 = mode_ff[`DTIC_MODE_CT0] ? fall[2] : (t0u_ff | tick12);
  assign src1 = mode_ff[`DTIC_MODE_CT1] ? fall[3] : (t1u_ff | tick12);
  assign run0 = tr0_ff && (!mode_ff[`DTIC_MODE_GATE0] || pin_sync_ff[0]);
  // Split timer 0 owns the timer 1 run bit, so timer 1 then runs free.
  assign run1 = (tr1_ff || t0_split) &&
                (!mode_ff[`DTIC_MODE_GATE1] || pin_sync_ff[1]);
  assign inc0_lo = run0 && src0;
  assign inc0_hi = t0_split && tr1_ff && (t0u_ff | tick12);
  assign inc1_lo = run1 && src1 && (m1 != dtic_mode_split);

  dtic_count_unit u_tmr0 (
    .aclk(aclk),
    .aresetn(aresetn),
    .mode(m0),
    .inc_lo(inc0_lo),
    .inc_hi(inc0_hi),
    .wr_lo(wr_t0lo),
    .wr_hi(wr_t0hi),
    .wdata(wd_ff),
    .lo(t0_lo),
    .hi(t0_hi),
    .ovf_lo(ovf0_lo),
    .ovf_hi(ovf0_hi)
  );

  dtic_count_unit u_tmr1 (
    .aclk(aclk),
    .aresetn(aresetn),
    .mode(m1),
    .inc_lo(inc1_lo),
    .inc_hi(1'b0),
    .wr_lo(wr_t1lo),
    .wr_hi(wr_t1hi),
    .wdata(wd_ff),
    .lo(t1_lo),
    .hi(t1_hi),
    .ovf_lo(ovf1_lo),
    .ovf_hi()
  );

  // Timer 1 overflows stay silent while timer 0 is split.
  assign set_tf1 = t0_split ? ovf0_hi : ovf1_lo;

  // Hardware set always wins over a software or vector clear.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tf0_ff <= 1'b0;
      tf1_ff <= 1'b0;
    end else begin
      if (ovf0_lo) begin
        tf0_ff <= 1'b1;
      end else if (wr_ctrl) begin
        tf0_ff <= wd_ff[`DTIC_CTRL_TF0];
      end else if (wr_vack && wd_ff[`DTIC_VACK_TF0]) begin
        tf0_ff <= 1'b0;
      end
      if (set_tf1) begin
        tf1_ff <= 1'b1;
      end else if (wr_ctrl) begin
        tf1_ff <= wd_ff[`DTIC_CTRL_TF1];
      end else if (wr_vack && wd_ff[`DTIC_VACK_TF1]) begin
        tf1_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ie0_ff <= 1'b0;
      ie1_ff <= 1'b0;
    end else begin
      // A write that enters level mode must not leave a stale request.
      if (!it0_ff || (wr_ctrl && !wd_ff[`DTIC_CTRL_IT0])) begin
        ie0_ff <= !pin_sync_ff[0];
      end else if (fall[0]) begin
        ie0_ff <= 1'b1;
      end else if (wr_ctrl) begin
        ie0_ff <= wd_ff[`DTIC_CTRL_IE0];
      end else if (wr_vack && wd_ff[`DTIC_VACK_EXTA]) begin
        ie0_ff <= 1'b0;
      end
      if (!it1_ff || (wr_ctrl && !wd_ff[`DTIC_CTRL_IT1])) begin
        ie1_ff <= !pin_sync_ff[1];
      end else if (fall[1]) begin
        ie1_ff <= 1'b1;
      end else if (wr_ctrl) begin
        ie1_ff <= wd_ff[`DTIC_CTRL_IE1];
      end else if (wr_vack && wd_ff[`DTIC_VACK_EXTB]) begin
        ie1_ff <= 1'b0;
      end
    end
  end

  assign awready = awready_ff;
  assign wready = wready_ff;
  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;
  assign arready = arready_ff;
  assign rvalid = rvalid_ff;
  assign rdata = rdata_ff;
  assign rresp = rresp_ff;
  assign tmr0_ovf_flag = tf0_ff;
  assign tmr1_ovf_flag = tf1_ff;
  assign ext_irq_a_pending = ie0_ff;
  assign ext_irq_b_pending = ie1_ff;

  default clocking dtic_cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_m0_wrap;
    inc0_lo && m0 == dtic_mode_13bit && t0_lo[4:0] == 5'h1f &&
    !wr_t0lo && !wr_t0hi;
  endsequence

  sequence s_t0_idle;
    !t0_split && !wr_t0lo && !wr_t0hi;
  endsequence

  a_m0_carry: assert property (
    s_m0_wrap |=> t0_lo[4:0] == 5'h00 && t0_hi == $past(t0_hi) + 8'h01)
    else $error("mode 0 carry into high byte wrong");
  a_m0_ovf: assert property (
    s_m0_wrap ##0 t0_hi == 8'hff |=> tmr0_ovf_flag && t0_hi == 8'h00)
    else $error("mode 0 wrap did not set flag");
  a_m2_reload: assert property (
    inc0_lo && m0 == dtic_mode_reload && t0_lo == 8'hff && !wr_t0lo
    |=> t0_lo == $past(t0_hi))
    else $error("mode 2 reload value wrong");
  a_run_off: assert property (
    !tr0_ff ##0 s_t0_idle |=> $stable(t0_lo) && $stable(t0_hi))
    else $error("timer 0 moved with run bit clear");
  a_gate_low: assert property (
    mode_ff[3] && !pin_sync_ff[0] ##0 s_t0_idle
    |=> $stable(t0_lo) && $stable(t0_hi))
    else $error("timer 0 moved with gate pin low");
  a_t1_hold: assert property (
    m1 == dtic_mode_split && !wr_t1lo && !wr_t1hi
    |=> $stable(t1_lo) && $stable(t1_hi))
    else $error("timer 1 moved in mode 3");
  a_split_tf1: assert property (
    t0_split && ovf1_lo && !ovf0_hi && !tf1_ff && !wr_ctrl
    |=> !tmr1_ovf_flag)
    else $error("timer 1 flagged while timer 0 split");
  a_lvl_a: assert property (
    !it0_ff |=> ext_irq_a_pending == !$past(pin_sync_ff[0]))
    else $error("level pending A does not follow pin");
  a_lvl_b: assert property (
    !it1_ff |=> ext_irq_b_pending == !$past(pin_sync_ff[1]))
    else $error("level pending B does not follow pin");
  a_edge_b: assert property (
    it1_ff && fall[1] |=> ext_irq_b_pending)
    else $error("falling edge B lost");
  a_vack_tf0: assert property (
    wr_vack && wd_ff[1] && !ovf0_lo |=> !tmr0_ovf_flag)
    else $error("vector acknowledge did not clear flag 0");
  a_div_twelve: assert property (
    tick12 |-> ##12 tick12)
    else $error("prescaler period is not twelve");
endmodule // dtic_timer_top
`default_nettype wire

// >>> test/dtic_pin_model.sv
// Purpose: Drives the gate, interrupt and event pins of the timer block.
// Assumes: Pins idle high; the bench calls the tasks from one process.
// Notes: Changes land just after a rising edge of aclk.
`timescale 1ns/1ps
`default_nettype none
module dtic_pin_model (
  input wire logic aclk,
  output logic ext_irq_pin_a,
  output logic ext_irq_pin_b,
  output logic tmr0_event_pin,
  output logic tmr1_event_pin
);
  initial begin
    ext_irq_pin_a = 1'b1;
    ext_irq_pin_b = 1'b1;
    tmr0_event_pin = 1'b1;
    tmr1_event_pin = 1'b1;
  end
  task automatic set_irq(input int i, input logic v);
    @(posedge aclk);
    if (i == 0) ext_irq_pin_a <= v;
    else ext_irq_pin_b <= v;
  endtask
  // Each low phase spans four clocks so the pin synchroniser cannot miss it.
  task automatic pulse_evt(input int i, input int n);
    for (int k = 0; k < n; k++) begin
      @(posedge aclk);
      if (i == 0) tmr0_event_pin <= 1'b0;
      else tmr1_event_pin <= 1'b0;
      repeat (4) @(posedge aclk);
      if (i == 0) tmr0_event_pin <= 1'b1;
      else tmr1_event_pin <= 1'b1;
      repeat (4) @(posedge aclk);
    end
  endtask
endmodule // dtic_pin_model
`default_nettype wire

// >>> test/testbench.sv
// Purpose: Self-checking bench for the timer block over AXI4-Lite.
// Assumes: Run windows are short, so counts are checked within bounds.
// Notes: Bus latency is not assumed; every wait follows the handshake.
`timescale 1ns/1ps
`default_nettype none
`include "dtic_defs.svh"
module testbench;
  logic aclk = 1'b0;
  logic aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, wr_resp, rd_resp;
  logic pin_a, pin_b, evt0, evt1, tf0, tf1, pend_a, pend_b;
  logic [7:0] rd_val, v1;
  logic [7:0] m_hi [3] = '{8'hff, 8'hff, 8'hc8};
  logic [7:0] lo_base [3] = '{8'h00, 8'h00, 8'hc8};
  logic [7:0] lo_mask [3] = '{8'h1f, 8'hff, 8'hff};
  int mismatches = 0;
  int tests_run = 0;
  int cycles = 0;
  int cu, cd;
  always #12.5 aclk = ~aclk;
  dtic_timer_top #(.ADDR_W(12)) DUT (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .ext_irq_pin_a(pin_a), .ext_irq_pin_b(pin_b),
    .tmr0_event_pin(evt0), .tmr1_event_pin(evt1),
    .tmr0_ovf_flag(tf0), .tmr1_ovf_flag(tf1),
    .ext_irq_a_pending(pend_a), .ext_irq_b_pending(pend_b)
  );
  dtic_pin_model PM (
    .aclk(aclk), .ext_irq_pin_a(pin_a), .ext_irq_pin_b(pin_b),
    .tmr0_event_pin(evt0), .tmr1_event_pin(evt1)
  );
  task automatic end_of_test();
    if (mismatches == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      end_of_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Address and data are offered together and each is released once taken.
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bit a, w;
    a = 1'b0;
    w = 1'b0;
    awaddr <= {2'b00, idx, 2'b00};
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(a && w)) begin
      @(posedge aclk);
      if (!a && awready) begin
        a = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w && wready) begin
        w = 1'b1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    wr_resp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] idx);
    araddr <= {2'b00, idx, 2'b00};
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rd_val = rdata[7:0];
    rd_resp = rresp;
    rready <= 1'b0;
  endtask
  function automatic logic pend_of(input int i);
    return (i == 0) ? pend_a : pend_b;
  endfunction
  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h00000000;
    wstrb = 4'h1;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    for (int k = 0; k < 7; k++) begin
      rd(8'h88 + 8'(k));
      chk(rd_val, 8'h00);
      chk(rd_resp, `DTIC_RESP_OKAY);
    end
    rd(8'h8f);
    chk(rd_resp, `DTIC_RESP_SLVERR);
    wr(8'h8f, 8'h5a);
    chk(wr_resp, `DTIC_RESP_SLVERR);
    for (int i = 0; i < 2; i++) begin
      wr(`DTIC_IDX_CTRL, (i == 0) ? 8'h01 : 8'h04);
      PM.set_irq(i, 1'b0);
      repeat (8) @(posedge aclk);
      chk(pend_of(i), 1'b1);
      PM.set_irq(i, 1'b1);
      repeat (8) @(posedge aclk);
      chk(pend_of(i), 1'b1);
      wr(`DTIC_IDX_CTRL, (i == 0) ? 8'h01 : 8'h04);
      chk(pend_of(i), 1'b0);
      PM.set_irq(i, 1'b0);
      repeat (3) @(posedge aclk);
      PM.set_irq(i, 1'b1);
      repeat (8) @(posedge aclk);
      chk(pend_of(i), 1'b1);
      wr(`DTIC_IDX_VACK, (i == 0) ? 8'h01 : 8'h04);
      chk(pend_of(i), 1'b0);
      wr(`DTIC_IDX_CTRL, (i == 0) ? 8'h02 : 8'h08);
      chk(pend_of(i), 1'b0);
      PM.set_irq(i, 1'b0);
      repeat (8) @(posedge aclk);
      chk(pend_of(i), 1'b1);
      PM.set_irq(i, 1'b1);
      repeat (8) @(posedge aclk);
      chk(pend_of(i), 1'b0);
    end
    for (int m = 0; m < 3; m++) begin
      wr(`DTIC_IDX_CTRL, 8'h00);
      wr(`DTIC_IDX_CLKSEL, 8'h08);
      wr(`DTIC_IDX_MODE, 8'(m));
      wr(`DTIC_IDX_T0LO, 8'hfe);
      wr(`DTIC_IDX_T0HI, m_hi[m]);
      chk(tf0, 1'b0);
      wr(`DTIC_IDX_CTRL, 8'h10);
      repeat (8) @(posedge aclk);
      chk(tf0, 1'b1);
      wr(`DTIC_IDX_CTRL, 8'h20);
      rd(`DTIC_IDX_T0HI);
      chk(rd_val, (m == 2) ? 8'hc8 : 8'h00);
      rd(`DTIC_IDX_T0LO);
      // Mode 0 leaves the top three low bits as written, so mask them.
      v1 = rd_val & lo_mask[m];
      chk(v1 >= lo_base[m] && v1 < lo_base[m] + 8'h18, 1'b1);
      wr(`DTIC_IDX_VACK, 8'h02);
      chk(tf0, 1'b0);
    end
    rd(`DTIC_IDX_T0LO);
    v1 = rd_val;
    repeat (30) @(posedge aclk);
    rd(`DTIC_IDX_T0LO);
    chk(rd_val, v1);
    wr(`DTIC_IDX_MODE, 8'h01);
    for (int s = 0; s < 2; s++) begin
      wr(`DTIC_IDX_CLKSEL, (s == 0) ? 8'h08 : 8'h00);
      wr(`DTIC_IDX_T0LO, 8'h00);
      wr(`DTIC_IDX_CTRL, 8'h10);
      repeat (96) @(posedge aclk);
      wr(`DTIC_IDX_CTRL, 8'h00);
      rd(`DTIC_IDX_T0LO);
      if (s == 0) cu = int'(rd_val);
      else cd = int'(rd_val);
    end
    chk(cu >= 96 && cu < 110, 1'b1);
    chk(cd == cu / 12 || cd == cu / 12 + 1, 1'b1);
    wr(`DTIC_IDX_MODE, 8'h09);
    wr(`DTIC_IDX_CLKSEL, 8'h08);
    wr(`DTIC_IDX_T0LO, 8'h00);
    PM.set_irq(0, 1'b0);
    wr(`DTIC_IDX_CTRL, 8'h10);
    repeat (20) @(posedge aclk);
    rd(`DTIC_IDX_T0LO);
    chk(rd_val, 8'h00);
    PM.set_irq(0, 1'b1);
    repeat (20) @(posedge aclk);
    rd(`DTIC_IDX_T0LO);
    chk(rd_val != 8'h00, 1'b1);
    wr(`DTIC_IDX_CTRL, 8'h00);
    wr(`DTIC_IDX_MODE, 8'h50);
    wr(`DTIC_IDX_T1LO, 8'hfb);
    wr(`DTIC_IDX_T1HI, 8'hff);
    wr(`DTIC_IDX_CTRL, 8'h40);
    PM.pulse_evt(1, 5);
    repeat (6) @(posedge aclk);
    chk(tf1, 1'b1);
    rd(`DTIC_IDX_T1LO);
    chk(rd_val, 8'h00);
    rd(`DTIC_IDX_T1HI);
    chk(rd_val, 8'h00);
    wr(`DTIC_IDX_VACK, 8'h08);
    chk(tf1, 1'b0);
    wr(`DTIC_IDX_CTRL, 8'h00);
    wr(`DTIC_IDX_MODE, 8'h03);
    wr(`DTIC_IDX_T0LO, 8'h40);
    wr(`DTIC_IDX_T0HI, 8'hfe);
    wr(`DTIC_IDX_CTRL, 8'h40);
    repeat (8) @(posedge aclk);
    chk(tf1, 1'b1);
    chk(tf0, 1'b0);
    rd(`DTIC_IDX_T0LO);
    chk(rd_val, 8'h40);
    wr(`DTIC_IDX_CTRL, 8'h00);
    wr(`DTIC_IDX_CLKSEL, 8'h18);
    wr(`DTIC_IDX_MODE, 8'h23);
    repeat (300) @(posedge aclk);
    chk(tf1, 1'b0);
    wr(`DTIC_IDX_MODE, 8'h30);
    wr(`DTIC_IDX_CTRL, 8'h40);
    wr(`DTIC_IDX_T1LO, 8'h33);
    repeat (30) @(posedge aclk);
    rd(`DTIC_IDX_T1LO);
    chk(rd_val, 8'h33);
    // A write with lane 0 disabled is answered but changes nothing.
    wstrb <= 4'h0;
    wr(`DTIC_IDX_T1HI, 8'h77);
    chk(wr_resp, `DTIC_RESP_OKAY);
    wstrb <= 4'h1;
    rd(`DTIC_IDX_T1HI);
    chk(rd_val, 8'h00);
    end_of_test();
  end
endmodule // testbench
`default_nettype wire
